// File: src/cpd_decode_out.sv
// classification, consistency and bus output logic of the tone decoder
//
// Summary of operation
// - line sampled at 9.3 khz from clock
// - call progress needs 340-700 hz, snr 16db
// - 145 ms consistency, assessment every 7 ms
// - 620 hz detector: 145 ms, every 55 ms
// - 620 hz band is 590 to 650 hz
// - code 0010 for non call progress
// - code 0000 when absent or out of span
// - decode word gated by level detector
// - interrupt whenever decode word changes
// - code 0001 for call progress dual tone
// - code 0011 for dual with 620 hz
// - code 0100 for special information tone
// - code 0101 for call progress single tone
// - code 0110 for single non call tone
// - code 0111 for single with 620 hz
// - code 1000 for fax/modem high tone
// - code 1100 for fax/modem low tone
// - reserved codes never presented
// - decode pins driven only while select low
// - open-drain irq low; select low clears
// - select held low gives 5 us pulse
// - enable low resets all and floats outputs
`timescale 1ns/1ps
`default_nettype none
module cpd_decode_out #(
    parameter int unsigned P_SAMPLE_CYC = cpd_pkg::CPD_SAMPLE_CYC, // sample period
    parameter int unsigned P_ASSESS_CYC = cpd_pkg::CPD_ASSESS_CYC, // 7 ms period
    parameter int unsigned P_A620_CYC   = cpd_pkg::CPD_A620_CYC    // 55 ms period
) (
    input  wire logic              i_clk_sys,          // system clock
    input  wire logic              i_nrst,             // async reset, active low
    input  wire logic              i_enable,           // low selects power save
    input  wire logic              i_level_ok,         // level detector flag
    input  wire cpd_pkg::cpd_feat_s i_feat,            // analyser features
    input  wire logic              i_output_select_n,  // host output select
    input  wire logic              i_change_irq_n_in,  // irq wire level
    output logic                   o_sample_stb,       // sample strobe to analyser
    output logic [3:0]             o_decode_bits,      // decode_bit3..decode_bit0
    output logic [3:0]             o_decode_oe,        // decode pin drive enables
    output logic                   o_change_irq_n_out, // irq pin level when driven
    output logic                   o_change_irq_n_oe   // irq pin pulls low
);
    import cpd_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // time base
    wire logic clr;     // power save restarts all timers
    wire logic tick;    // 7 ms assessment enable
    wire logic tick620; // 55 ms assessment enable

    assign clr = ~i_enable;

    // sample strobe, counted from the clock
    cpd_tick_gen #(.PERIOD(P_SAMPLE_CYC)) u_smp (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_clr     (clr),
        .o_tick    (o_sample_stb)
    );

    // main assessment interval
    cpd_tick_gen #(.PERIOD(P_ASSESS_CYC)) u_ass (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_clr     (clr),
        .o_tick    (tick)
    );

    // 620 hz assessment interval
    cpd_tick_gen #(.PERIOD(P_A620_CYC)) u_620 (
        .i_clk_sys (i_clk_sys),
        .i_nrst    (i_nrst),
        .i_clr     (clr),
        .o_tick    (tick620)
    );

    ////////////////////////////////////////////////////////////////////////////
    // frequency tests
    function automatic logic in_rng(cpd_freq_t f, cpd_freq_t lo, cpd_freq_t hi);
        return (f >= lo) && (f <= hi);
    endfunction : in_rng

    wire cpd_freq_t f_a;     // lower or only component
    wire cpd_freq_t f_b;     // upper component, or the only one again
    wire logic      pres;    // tonal energy present
    wire logic      single;  // one component only
    wire logic      in_span; // some component inside the decode span
    wire logic      all_cp;  // every component in call progress band
    wire logic      any_cp;  // some component in call progress band
    wire logic      all_ncp; // every component in non call range
    wire logic      snr_ok;  // quality good enough
    wire logic      fax_hi;  // fax/modem high tone
    wire logic      fax_lo;  // fax/modem low tone
    wire logic      sit;     // special information tone
    wire logic      hit620;  // component inside 620 hz band

    assign f_a     = i_feat.f_lo;
    assign f_b     = i_feat.dual ? i_feat.f_hi : i_feat.f_lo;
    assign pres    = i_feat.present;
    assign single  = ~i_feat.dual;
    assign in_span = in_rng(f_a, CPD_SPAN_LO, CPD_SPAN_HI)
                   | in_rng(f_b, CPD_SPAN_LO, CPD_SPAN_HI);
    assign all_cp  = in_rng(f_a, CPD_CP_LO, CPD_CP_HI) & in_rng(f_b, CPD_CP_LO, CPD_CP_HI);
    assign any_cp  = in_rng(f_a, CPD_CP_LO, CPD_CP_HI) | in_rng(f_b, CPD_CP_LO, CPD_CP_HI);
    assign all_ncp = in_rng(f_a, CPD_NCP_LO, CPD_NCP_HI)
                   & in_rng(f_b, CPD_NCP_LO, CPD_NCP_HI);
    assign snr_ok  = (i_feat.snr_db >= CPD_SNR_MIN);
    assign fax_hi  = in_rng(f_a, CPD_FAXH_LO, CPD_FAXH_HI)
                   & in_rng(f_b, CPD_FAXH_LO, CPD_FAXH_HI);
    assign fax_lo  = in_rng(f_a, CPD_FAXL_LO, CPD_FAXL_HI)
                   & in_rng(f_b, CPD_FAXL_LO, CPD_FAXL_HI);
    assign sit     = single & (in_rng(f_a, CPD_SIT_A - CPD_SIT_TOL, CPD_SIT_A + CPD_SIT_TOL)
                   | in_rng(f_a, CPD_SIT_B - CPD_SIT_TOL, CPD_SIT_B + CPD_SIT_TOL)
                   | in_rng(f_a, CPD_SIT_C - CPD_SIT_TOL, CPD_SIT_C + CPD_SIT_TOL));
    // single tone or either component of a dual
    assign hit620  = pres & (in_rng(f_a, CPD_D620_LO, CPD_D620_HI)
                   | in_rng(f_b, CPD_D620_LO, CPD_D620_HI));

    ////////////////////////////////////////////////////////////////////////////
    // 620 hz detector
    logic [CPD_C620_W-1:0] cnt620; // consecutive 55 ms hits, saturating
    wire  logic            det620; // 620 hz detected

    // consecutive hits at each 55 ms update
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cnt620 <= '0;
        end else if (clr || (tick620 && !hit620)) begin
            cnt620 <= '0;
        end else if (tick620 && cnt620 != CPD_C620_N) begin
            cnt620 <= cnt620 + 1'b1;
        end
    end

    assign det620 = (cnt620 >= CPD_C620_N);

    ////////////////////////////////////////////////////////////////////////////
    // candidate code, highest priority first
    cpd_code_e cand; // this assessment's verdict

    always_comb begin
        if (!pres || !in_span) begin
            cand = CPD_NO_SIG;
        end else if (fax_hi) begin
            cand = CPD_FAX_HIGH;
        end else if (fax_lo) begin
            cand = CPD_FAX_LOW;
        end else if (sit) begin
            cand = CPD_SIT;
        end else if (all_cp && snr_ok) begin
            if (single) begin
                cand = det620 ? CPD_CP_SINGLE620 : CPD_CP_SINGLE;
            end else begin
                cand = det620 ? CPD_CP_DUAL620 : CPD_CP_DUAL;
            end
        end else if (all_ncp && single && !any_cp) begin
            cand = CPD_NCP_SINGLE;
        end else if (all_ncp) begin
            cand = CPD_NCP;
        end else begin
            cand = CPD_NO_SIG;                              // tone of no known class
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // consistency filter
    cpd_code_e             cand_prev;   // verdict of the last assessment
    cpd_code_e             commit;      // accepted classification
    logic [CPD_STAB_W-1:0] stab;        // equal verdicts in a row
    wire  logic            same;        // verdict repeats
    wire  logic [CPD_STAB_W-1:0] next_stab;
    wire  cpd_code_e       next_commit;

    assign same      = (cand == cand_prev);
    assign next_stab = !same ? CPD_STAB_W'(1)
                     : (stab == CPD_CONSIST_N) ? stab : stab + 1'b1;
    // accepted only after 145 ms of one verdict
    assign next_commit = (tick && next_stab >= CPD_CONSIST_N) ? cand : commit;

    // track verdicts at each 7 ms update
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            cand_prev <= CPD_NO_SIG;
            stab      <= '0;
            commit    <= CPD_NO_SIG;
        end else if (clr) begin
            cand_prev <= CPD_NO_SIG;
            stab      <= '0;
            commit    <= CPD_NO_SIG;
        end else if (tick) begin
            cand_prev <= cand;
            stab      <= next_stab;
            commit    <= next_commit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // presented word and change detect
    cpd_code_e  out_code; // word on the decode pins
    wire cpd_code_e gated; // level-gated result
    wire logic  changed;  // word changes this cycle

    assign gated   = i_level_ok ? next_commit : CPD_NO_SIG;
    assign changed = tick && (gated != out_code);

    // update the word at each assessment
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            out_code <= CPD_NO_SIG;
        end else if (clr) begin
            out_code <= CPD_NO_SIG;
        end else if (tick) begin
            out_code <= gated;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt: held level, or pulse while select is low
    logic                   pending;   // held request awaiting select
    logic [CPD_PULSE_W-1:0] pulse_cnt; // pulse cycles left
    wire  logic             sel_low;   // host selects the outputs
    wire  logic             pulse_act; // pulse in progress
    wire  logic             irq_drive; // pull the irq wire low

    assign sel_low   = ~i_output_select_n;
    assign pulse_act = (pulse_cnt != '0);
    assign irq_drive = pending | pulse_act;

    // held request; set by a change while select is high, cleared by select low or power save
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pending <= 1'b0;
        end else if (clr) begin
            pending <= 1'b0;
        end else if (changed && !sel_low) begin
            pending <= 1'b1;
        end else if (sel_low) begin
            pending <= 1'b0;
        end
    end

    // pulse when the change meets select already low
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            pulse_cnt <= '0;
        end else if (clr) begin
            pulse_cnt <= '0;
        end else if (changed && sel_low) begin
            pulse_cnt <= CPD_PULSE_LOAD;
        end else if (pulse_act) begin
            pulse_cnt <= pulse_cnt - 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pins
    assign o_decode_bits      = out_code;
    assign o_decode_oe        = {4{sel_low & i_enable}};
    assign o_change_irq_n_out = 1'b0;                           // open drain
    assign o_change_irq_n_oe  = irq_drive;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    localparam int PULSE_HOLD = int'(CPD_PULSE_CYC) - 1;
    localparam int SMP_W      = $clog2(P_SAMPLE_CYC) + 1;

    logic [SMP_W-1:0] smp_gap;  // cycles since last strobe
    logic             smp_seen; // a strobe occurred since enable

    // strobe spacing monitor
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            smp_gap  <= '0;
            smp_seen <= 1'b0;
        end else if (clr || o_sample_stb) begin
            smp_gap  <= '0;
            smp_seen <= o_sample_stb;
        end else begin
            smp_gap  <= smp_gap + 1'b1;
        end
    end

    sequence seq_pulse_start;
        changed && sel_low && i_enable;
    endsequence

    sequence seq_pulse_body;
        ##1 pulse_act ##PULSE_HOLD pulse_act ##1 !pulse_act;
    endsequence

    chk_sample_period: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (o_sample_stb && smp_seen && i_enable) |-> (smp_gap == SMP_W'(P_SAMPLE_CYC - 1)))
        else $error("sample strobe spacing wrong");

    chk_no_reserved: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !(o_decode_bits inside {4'h9, 4'ha, 4'hb, 4'hd, 4'he, 4'hf}))
        else $error("reserved decode code presented");

    chk_level_gate: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (tick && !i_level_ok) |=> (o_decode_bits == CPD_NO_SIG))
        else $error("decode word not gated by level flag");

    chk_change_irq: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (i_enable && $past(i_enable) && $changed(o_decode_bits)) |-> o_change_irq_n_oe)
        else $error("decode change raised no interrupt");

    chk_select_float: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        i_output_select_n |-> (o_decode_oe == 4'h0))
        else $error("decode pins driven while deselected");

    chk_power_save: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        !i_enable |=> (o_decode_bits == CPD_NO_SIG) && !o_change_irq_n_oe && !pending)
        else $error("power save did not reset state");

    chk_pulse_width: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst || !i_enable)
        seq_pulse_start |-> seq_pulse_body)
        else $error("interrupt pulse width wrong");

    chk_irq_clear: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (pending && sel_low && !pulse_act && !changed) |=> !o_change_irq_n_oe)
        else $error("select low did not clear interrupt");

    chk_commit_wait: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        (i_enable && $past(i_enable) && $changed(commit))
            |-> $past(tick) && (stab >= CPD_CONSIST_N))
        else $error("classification accepted too early");

    chk_irq_wire: assert property (
        @(posedge i_clk_sys) disable iff (!i_nrst)
        o_change_irq_n_oe |-> !i_change_irq_n_in)
        else $error("irq wire not low while pulled");
endmodule : cpd_decode_out
`default_nettype wire

// File: src/cpd_pkg.sv
// constants, codes and carrier types of the call-progress decode output block
package cpd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and time base
    localparam int unsigned CPD_CLK_HZ     = 25_000_000; // system clock rate
    localparam int unsigned CPD_CLK_NS     = 40;         // system clock period
    localparam int unsigned CPD_MS_PER_S   = 1000;       // unit conversion
    localparam int unsigned CPD_SAMPLE_HZ  = 9300;       // line sample rate
    localparam int unsigned CPD_ASSESS_MS  = 7;          // main assessment interval
    localparam int unsigned CPD_A620_MS    = 55;         // 620 hz assessment interval
    localparam int unsigned CPD_CONSIST_MS = 145;        // least consistent time
    localparam int unsigned CPD_PULSE_NS   = 5000;       // irq pulse, select held low

    // derived cycle counts
    localparam int unsigned CPD_SAMPLE_CYC = CPD_CLK_HZ / CPD_SAMPLE_HZ;
    localparam int unsigned CPD_ASSESS_CYC = CPD_CLK_HZ / CPD_MS_PER_S * CPD_ASSESS_MS;
    localparam int unsigned CPD_A620_CYC   = CPD_CLK_HZ / CPD_MS_PER_S * CPD_A620_MS;
    localparam int unsigned CPD_PULSE_CYC  = (CPD_PULSE_NS + CPD_CLK_NS - 1) / CPD_CLK_NS;

    // counter widths and thresholds, in assessments; pulse load in clock cycles
    localparam int unsigned CPD_STAB_W  = 5;
    localparam int unsigned CPD_C620_W  = 2;
    localparam int unsigned CPD_PULSE_W = 7;
    localparam logic [CPD_STAB_W-1:0] CPD_CONSIST_N =
        CPD_STAB_W'((CPD_CONSIST_MS + CPD_ASSESS_MS - 1) / CPD_ASSESS_MS);
    localparam logic [CPD_C620_W-1:0] CPD_C620_N =
        CPD_C620_W'((CPD_CONSIST_MS + CPD_A620_MS - 1) / CPD_A620_MS);
    localparam logic [CPD_PULSE_W-1:0] CPD_PULSE_LOAD = CPD_PULSE_W'(CPD_PULSE_CYC);

    ////////////////////////////////////////////////////////////////////////////
    // frequency limits in hz
    typedef logic [11:0] cpd_freq_t;
    localparam cpd_freq_t CPD_SPAN_LO = 12'h0b4; // 180
    localparam cpd_freq_t CPD_SPAN_HI = 12'h8e8; // 2280
    localparam cpd_freq_t CPD_NCP_LO  = 12'h0be; // 190
    localparam cpd_freq_t CPD_NCP_HI  = 12'h37f; // 895
    localparam cpd_freq_t CPD_CP_LO   = 12'h154; // 340
    localparam cpd_freq_t CPD_CP_HI   = 12'h2bc; // 700
    localparam cpd_freq_t CPD_D620_LO = 12'h24e; // 590
    localparam cpd_freq_t CPD_D620_HI = 12'h28a; // 650
    localparam cpd_freq_t CPD_FAXH_LO = 12'h834; // 2100
    localparam cpd_freq_t CPD_FAXH_HI = 12'h898; // 2200
    localparam cpd_freq_t CPD_FAXL_LO = 12'h4b0; // 1200
    localparam cpd_freq_t CPD_FAXL_HI = 12'h514; // 1300
    localparam cpd_freq_t CPD_SIT_A   = 12'h3b6; // 950
    localparam cpd_freq_t CPD_SIT_B   = 12'h578; // 1400
    localparam cpd_freq_t CPD_SIT_C   = 12'h708; // 1800
    localparam cpd_freq_t CPD_SIT_TOL = 12'h032; // 50 either side
    localparam logic [7:0] CPD_SNR_MIN = 8'h10;  // 16 db

    ////////////////////////////////////////////////////////////////////////////
    // decode word values; reserved codes have no member
    typedef enum logic [3:0] {
        CPD_NO_SIG       = 4'h0,
        CPD_CP_DUAL      = 4'h1,
        CPD_NCP          = 4'h2,
        CPD_CP_DUAL620   = 4'h3,
        CPD_SIT          = 4'h4,
        CPD_CP_SINGLE    = 4'h5,
        CPD_NCP_SINGLE   = 4'h6,
        CPD_CP_SINGLE620 = 4'h7,
        CPD_FAX_HIGH     = 4'h8,
        CPD_FAX_LOW      = 4'hc
    } cpd_code_e;

    // spectral features from the upstream analyser
    typedef struct packed {
        logic       present; // any tonal energy seen
        logic       dual;    // two components
        cpd_freq_t  f_lo;    // lower or only component
        cpd_freq_t  f_hi;    // upper component when dual
        logic [7:0] snr_db;  // signal to noise in db
    } cpd_feat_s;

endpackage : cpd_pkg

// File: src/cpd_tick_gen.sv
// free-running divider giving a one-cycle enable every period cycles
`timescale 1ns/1ps
`default_nettype none
module cpd_tick_gen #(
    parameter int unsigned PERIOD = 2
) (
    input  wire logic i_clk_sys, // system clock
    input  wire logic i_nrst,    // async reset, active low
    input  wire logic i_clr,     // sync restart
    output logic      o_tick     // one-cycle enable
);
    localparam int unsigned   CW   = $clog2(PERIOD);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] count; // cycles into the period
    wire  logic    at_last;

    assign at_last = (count == LAST);

    ////////////////////////////////////////////////////////////////////////////
    // count and wrap
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            count <= '0;
        end else if (i_clr || at_last) begin
            count <= '0;
        end else begin
            count <= count + 1'b1;
        end
    end

    assign o_tick = at_last & ~i_clr;
endmodule : cpd_tick_gen
`default_nettype wire

// File: verification/cpd_host_model.sv
// host controller model that reads the decode word
`timescale 1ns/1ps
`default_nettype none
module cpd_host_model (
    input  wire logic       i_clk_sys, // system clock
    input  wire logic [3:0] i_bus,     // resolved decode pins
    output logic            o_sel_n    // output select, active low
);
    // idle with the decode pins released
    initial o_sel_n = 1'b1;
    // one-cycle read; select held until the falling edge after the sampling edge
    task automatic read(output logic [3:0] d);
        @(negedge i_clk_sys) o_sel_n = 1'b0;
        @(posedge i_clk_sys) d = i_bus;
        @(negedge i_clk_sys) o_sel_n = 1'b1;
    endtask : read
    // select parked low or released
    task automatic hold(input logic v);
        @(negedge i_clk_sys) o_sel_n = ~v;
    endtask : hold
endmodule : cpd_host_model
`default_nettype wire

// File: verification/test_call_progress_tone_decode_output.sv
// testbench of the call-progress decode output block
`timescale 1ns/1ps
`default_nettype none
module test_call_progress_tone_decode_output;
    import cpd_pkg::*;
    localparam int SC = 8;  // shortened sample period
    localparam int AC = 20; // shortened 7 ms period
    logic       clk, nrst, en, lvl, stb, irq_out, irq_oe;
    logic       sel_n;          // from host model
    logic [3:0] bits, oe;
    cpd_feat_s  feat;           // analyser features
    wire  [3:0] bus;            // decode pins
    wire        irq_n;          // irq wire with pull-up
    int         fail_count, samples_checked;

    ////////////////////////////////////////////////////////////////////////
    // clock, pins, instances
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    for (genvar g = 0; g < 4; g++) begin : g_pin
        assign bus[g] = oe[g] ? bits[g] : 1'bz;
    end
    assign irq_n = irq_oe ? irq_out : 1'b1;
    cpd_decode_out #(.P_SAMPLE_CYC(SC), .P_ASSESS_CYC(AC), .P_A620_CYC(64)) u_dut (
        .i_clk_sys(clk), .i_nrst(nrst), .i_enable(en), .i_level_ok(lvl),
        .i_feat(feat), .i_output_select_n(sel_n), .i_change_irq_n_in(irq_n),
        .o_sample_stb(stb), .o_decode_bits(bits), .o_decode_oe(oe),
        .o_change_irq_n_out(irq_out), .o_change_irq_n_oe(irq_oe));
    cpd_host_model u_host (.i_clk_sys(clk), .i_bus(bus), .o_sel_n(sel_n));

    ////////////////////////////////////////////////////////////////////////
    // compare and helper tasks
    task automatic chk_v(input logic [3:0] got, input logic [3:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %0t: value %h, want %h", $time, got, exp);
        end
    endtask : chk_v
    task automatic chk_n(input int got, input int exp);
        samples_checked++;
        if (got != exp) begin
            fail_count++;
            $display("unexpected %0t: count %0d, want %0d", $time, got, exp);
        end
    endtask : chk_n
    // tone features, single unless dual given
    function automatic cpd_feat_s ft(logic [11:0] lo, logic [11:0] hi = 12'h000,
                                     logic d = 1'b0, logic [7:0] s = 8'h14);
        return '{1'b1, d, lo, hi, s};
    endfunction : ft

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    // strobe spacing in cycles
    task automatic strobe_rate();
        int n;
        n = 0;
        while (stb !== 1'b1 && n < 40) @(negedge clk) n++;
        n = 0;
        do @(negedge clk) n++; while (stb !== 1'b1 && n < 40);
        chk_n(n, SC);
    endtask : strobe_rate
    // new class: response time, pending irq, floating pins, read-out
    task automatic step(input cpd_feat_s f, input logic [3:0] e);
        int n;
        logic [3:0] d;
        n = 0;
        @(negedge clk) feat = f;
        while (bits !== e && n < 1500) @(negedge clk) n++;
        chk_n(int'(n > (int'(CPD_CONSIST_N) - 1) * AC), 1);
        chk_v({3'h0, irq_n}, 4'h0);
        chk_v(bus, 4'hz);
        u_host.read(d);
        chk_v(d, e);
        chk_v({3'h0, irq_n}, 4'h1);
    endtask : step
    // power save with select low, then level gating and pulse mode
    task automatic power_level();
        int n;
        u_host.hold(1'b1);
        @(negedge clk) en = 1'b0;
        @(negedge clk) chk_v(bus, 4'hz);
        chk_v(bits, 4'h0);
        en = 1'b1;
        lvl = 1'b0;
        feat = ft(12'h1a9);
        repeat (600) @(negedge clk);
        chk_v({bits[3:1], irq_n}, 4'h1);
        lvl = 1'b1;
        n = 0;
        while (irq_n !== 1'b0 && n < 1000) @(negedge clk) n++;
        n = 0;
        while (irq_n === 1'b0 && n < 300) @(negedge clk) n++;
        chk_n(n, 125);
        chk_v(bus, 4'h5);
        u_host.hold(1'b0);
    endtask : power_level

    ////////////////////////////////////////////////////////////////////////
    // main sequence, watchdog, verdict
    initial begin
        {nrst, en, lvl, feat} = {1'b0, 1'b1, 1'b1, 34'h0};
        fail_count = 0;
        samples_checked = 0;
        repeat (5) @(negedge clk);
        nrst = 1'b1;
        strobe_rate();
        step(ft(12'h866), 4'h8);
        step(ft(12'h4e2), 4'hc);
        step(ft(12'h578), 4'h4);
        step(ft(12'h1a9), 4'h5);
        step(ft(12'h1a9, 12'h000, 1'b0, 8'h0a), 4'h2);
        step(ft(12'h15e, 12'h1b8, 1'b1), 4'h1);
        step(ft(12'h26c), 4'h7);
        step(ft(12'h1e0, 12'h26c, 1'b1), 4'h3);
        step(ft(12'h0fa), 4'h6);
        step(ft(12'h7d0), 4'h0);
        step(ft(12'h0fa, 12'h320, 1'b1), 4'h2);
        power_level();
        step(ft(12'h960), 4'h0);
        finish_test();
    end
    initial begin
        repeat (40000) @(posedge clk);
        fail_count++;
        finish_test();
    end
    task automatic finish_test();
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
endmodule : test_call_progress_tone_decode_output
`default_nettype wire
